// file: rtl/rtt_chan.sv
`timescale 1ns/1ps
module rtt_chan (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// comparator and fine time
	input wire logic comp,
	input wire logic [rtt_pkg::FINE_W-1:0] fine,
	// timing context
	input wire logic win,
	input wire logic earth,
	input wire logic [rtt_pkg::COARSE_W-1:0] coarse,
	input wire logic origin,
	input wire logic [rtt_pkg::CNT_W-1:0] noise_lim,
	// results
	output rtt_pkg::rtt_stamp_t stamp,
	output logic stamp_vld,
	output logic [rtt_pkg::CNT_W-1:0] evt_cnt,
	output logic [rtt_pkg::CNT_W-1:0] noise_cnt,
	output logic noisy
);
	import rtt_pkg::*;
	typedef struct packed {
		logic comp_q;
		rtt_stamp_t stamp;
		logic vld;
		logic [CNT_W-1:0] evt;
		logic [CNT_W-1:0] run;
		logic [CNT_W-1:0] held;
		logic noisy;
	} rtt_chan_st_t;
	rtt_chan_st_t st_ff;
	rtt_chan_st_t nxt_st;
	logic rise;
	logic fall;
	// ************************************************************
	// edge capture and counters
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		rise = comp & ~st_ff.comp_q;
		fall = ~comp & st_ff.comp_q;
		nxt_st.comp_q = comp;
		nxt_st.vld = 1'b0;
		if ((rise | fall) && win) begin
			nxt_st.stamp.earth = earth;
			nxt_st.stamp.fall = fall;
			nxt_st.stamp.coarse = coarse;
			nxt_st.stamp.fine = fine;
			nxt_st.vld = 1'b1;
			nxt_st.evt = rtt_sat_inc(st_ff.evt);
		end
		if (origin) begin
			nxt_st.held = st_ff.run;
			nxt_st.run = rise ? CNT_W'(1) : '0;
			nxt_st.noisy = (st_ff.run > noise_lim);
		end else if (rise) begin
			nxt_st.run = rtt_sat_inc(st_ff.run);
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign stamp = st_ff.stamp;
	assign stamp_vld = st_ff.vld;
	assign evt_cnt = st_ff.evt;
	assign noise_cnt = st_ff.held;
	assign noisy = st_ff.noisy;
	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	outside_drop_a: assert property (!win |=> !st_ff.vld)
		else $error("edge accepted outside window");
	evt_step_a: assert property (st_ff.vld && $past(st_ff.evt) != '1
		|-> st_ff.evt == CNT_W'($past(st_ff.evt) + 1'b1))
		else $error("event count not stepped");
	fall_stamp_a: assert property (win && st_ff.comp_q && !comp
		|=> st_ff.vld && st_ff.stamp.fall)
		else $error("falling edge not stamped");
	stamp_value_a: assert property (win && rise
		|=> st_ff.stamp.coarse == $past(coarse) && st_ff.stamp.fine == $past(fine))
		else $error("stamp value wrong");
	noise_hold_a: assert property (!origin |=> $stable(st_ff.held))
		else $error("noise count moved mid frame");
	noise_take_a: assert property (origin |=> st_ff.held == $past(st_ff.run))
		else $error("noise count not taken at origin");
endmodule : rtt_chan

// file: rtl/rtt_div.sv
`timescale 1ns/1ps
module rtt_div #(
	parameter int unsigned DIV = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// count enable and divided pulse
	input wire logic en,
	output logic pulse
);
	import rtt_pkg::*;
	localparam int unsigned W = $clog2(DIV + 1);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic pulse;
	} rtt_div_st_t;
	rtt_div_st_t st_ff;
	rtt_div_st_t nxt_st;
	// ************************************************************
	// divider
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pulse = 1'b0;
		if (en) begin
			if (st_ff.cnt == W'(DIV - 1)) begin
				nxt_st.cnt = '0;
				nxt_st.pulse = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign pulse = st_ff.pulse;
endmodule : rtt_div

// file: rtl/rtt_pkg.sv
// What this block does
// - divide 20 MHz reference to 5 MHz ticks
// - align all framing to 1 Hz pulse
// - free-run on own oscillator without reference
// - measure own oscillator against stable reference
// - 28 Hz firing locked to second pulse
// - 28 minor frames per one-second major frame
// - 8 ms earth window each minor frame
// - separate surface return window each frame
// - telemetry transfer slot each minor frame
// - sync analog side, reset energy latches
// - 200 ns coarse timer shared by all channels
// - noise and event counters per channel
// - calibration counters for twelve fine timers
// - six channels: fire plus five returns
// - return channel one shared with earth window
// - timestamp is coarse count plus fine value
// - stamp fire, five returns, earth pulse
// - per-detector gain and threshold values
// - comparator enable silences noisy channel
// - stamp both rising and falling edges
// - surface window 0 to 5 ms after fire
// - fire about 9.66 ms after frame origin
package rtt_pkg;
	// ************************************************************
	// rates and times
	// ************************************************************
	localparam int unsigned SYS_HZ = 25_000_000;
	localparam int unsigned SRO_HZ = 20_000_000;
	localparam int unsigned REF_HZ = 5_000_000;
	localparam int unsigned SRO_DIV = SRO_HZ / REF_HZ;
	localparam int unsigned SYS_DIV = SYS_HZ / REF_HZ;
	localparam int unsigned FIRE_HZ = 28;
	localparam int unsigned MINORS = 28;
	localparam int unsigned TICKS_PER_US = REF_HZ / 1_000_000;
	localparam int unsigned MINOR_TICKS = REF_HZ / FIRE_HZ;
	localparam int unsigned EARTH_WIN_US = 8000;
	localparam int unsigned EARTH_TICKS = EARTH_WIN_US * TICKS_PER_US;
	localparam int unsigned FIRE_DLY_US = 9660;
	localparam int unsigned FIRE_TICKS = FIRE_DLY_US * TICKS_PER_US;
	localparam int unsigned SURF_MAX_US = 5000;
	localparam int unsigned SURF_MAX_TICKS = SURF_MAX_US * TICKS_PER_US;
	localparam int unsigned TLM_SLOT_US = 30000;
	localparam int unsigned TLM_TICKS = TLM_SLOT_US * TICKS_PER_US;
	localparam int unsigned PPS_SLACK = 64;
	localparam int unsigned REF_LOSS_CYC = 8;
	localparam int unsigned GATE_TICKS = REF_HZ;
	// ************************************************************
	// sizes and widths
	// ************************************************************
	localparam int unsigned NUM_CH = 6;
	localparam int unsigned NUM_RET = 5;
	localparam int unsigned NUM_TDC = 12;
	localparam int unsigned COARSE_W = 24;
	localparam int unsigned FINE_W = 16;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DAC_W = 12;
	localparam int unsigned DLY_W = 15;
	localparam int unsigned TICK_W = 18;
	localparam int unsigned MINOR_W = 5;
	localparam int unsigned LOSS_W = 4;
	localparam int unsigned GATE_W = 23;
	localparam int unsigned OSC_W = 25;
	localparam int unsigned CH_FIRE = 0;
	localparam int unsigned CH_SHARED = 1;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [4:0] {
		PH_EARTH = 5'h01,
		PH_AIM = 5'h02,
		PH_DELAY = 5'h04,
		PH_SURF = 5'h08,
		PH_TLM = 5'h10
	} rtt_phase_t;
	typedef struct packed {
		logic earth;
		logic fall;
		logic [COARSE_W-1:0] coarse;
		logic [FINE_W-1:0] fine;
	} rtt_stamp_t;
	typedef struct packed {
		logic [DAC_W-1:0] gain;
		logic [DAC_W-1:0] thr;
		logic en;
	} rtt_det_cfg_t;
	function automatic logic [CNT_W-1:0] rtt_sat_inc(input logic [CNT_W-1:0] v);
		return (v == '1) ? v : v + 1'b1;
	endfunction : rtt_sat_inc
endpackage : rtt_pkg

// file: rtl/rtt_top.sv
`timescale 1ns/1ps
module rtt_top #(
	parameter int unsigned MINOR_TICKS = rtt_pkg::MINOR_TICKS,
	parameter int unsigned EARTH_TICKS = rtt_pkg::EARTH_TICKS,
	parameter int unsigned FIRE_TICKS = rtt_pkg::FIRE_TICKS,
	parameter int unsigned SURF_MAX_TICKS = rtt_pkg::SURF_MAX_TICKS,
	parameter int unsigned TLM_TICKS = rtt_pkg::TLM_TICKS,
	parameter int unsigned GATE_TICKS = rtt_pkg::GATE_TICKS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// spacecraft timing
	input wire logic sro_clk,
	input wire logic pps,
	// command side
	input wire logic [rtt_pkg::DLY_W-1:0] surf_dly,
	input wire rtt_pkg::rtt_det_cfg_t [rtt_pkg::NUM_RET-1:0] det_cfg,
	input wire logic [rtt_pkg::CNT_W-1:0] noise_lim,
	// detector and fine timer side
	input wire logic [rtt_pkg::NUM_CH-1:0] comp,
	input wire logic [rtt_pkg::NUM_CH-1:0][rtt_pkg::FINE_W-1:0] fine,
	input wire logic [rtt_pkg::NUM_RET-1:0] adc_done,
	input wire logic [rtt_pkg::NUM_TDC-1:0] tdc_slip,
	// timing outputs
	output logic ref_ok,
	output logic frame_origin,
	output logic [rtt_pkg::MINOR_W-1:0] minor_idx,
	output logic earth_win,
	output logic surf_win,
	output logic fire_cmd,
	output logic tlm_slot,
	// detector controls
	output rtt_pkg::rtt_det_cfg_t [rtt_pkg::NUM_RET-1:0] det_ctl,
	output logic [rtt_pkg::NUM_RET-1:0] latch_rst,
	// measurement results
	output rtt_pkg::rtt_stamp_t [rtt_pkg::NUM_CH-1:0] stamp,
	output logic [rtt_pkg::NUM_CH-1:0] stamp_vld,
	output logic [rtt_pkg::NUM_CH-1:0][rtt_pkg::CNT_W-1:0] evt_cnt,
	output logic [rtt_pkg::NUM_CH-1:0][rtt_pkg::CNT_W-1:0] noise_cnt,
	output logic [rtt_pkg::NUM_TDC-1:0][rtt_pkg::CNT_W-1:0] cal_cnt,
	output logic [rtt_pkg::OSC_W-1:0] osc_cnt
);
	import rtt_pkg::*;
	typedef struct packed {
		logic sro_q;
		logic pps_q;
		logic [LOSS_W-1:0] loss;
		logic ref_ok;
		logic pps_lock;
		rtt_phase_t phase;
		logic [TICK_W-1:0] tick_cnt;
		logic [COARSE_W-1:0] maj_cnt;
		logic [MINOR_W-1:0] minor;
		logic [DLY_W-1:0] dly_cnt;
		logic origin;
		logic fire;
		rtt_det_cfg_t [NUM_RET-1:0] det;
		logic [NUM_RET-1:0] latch;
		logic [NUM_TDC-1:0][CNT_W-1:0] cal_run;
		logic [NUM_TDC-1:0][CNT_W-1:0] cal_held;
		logic [GATE_W-1:0] gate_cnt;
		logic [OSC_W-1:0] osc_run;
		logic [OSC_W-1:0] osc_held;
	} rtt_top_st_t;
	rtt_top_st_t st_ff;
	rtt_top_st_t nxt_st;
	logic sro_rise;
	logic pps_rise;
	logic sro_tick;
	logic int_tick;
	logic tick;
	logic major;
	logic [DLY_W-1:0] dly;
	logic [TICK_W-1:0] end_cnt;
	logic [NUM_CH-1:0] ch_win;
	logic [NUM_CH-1:0] ch_noisy;
	logic [NUM_RET-1:0] ctl_en;

	// ************************************************************
	// window decode
	// ************************************************************
	function automatic logic rtt_ch_win(input rtt_phase_t ph, input int unsigned ch);
		logic w;
		w = (ph == PH_SURF);
		if (ch == CH_FIRE) begin
			w = (ph == PH_DELAY) || (ph == PH_SURF);
		end else if (ch == CH_SHARED) begin
			w = (ph == PH_EARTH) || (ph == PH_SURF);
		end
		return w;
	endfunction : rtt_ch_win

	// ************************************************************
	// reference dividers
	// ************************************************************
	rtt_div #(
		.DIV(SRO_DIV)
	) u_sro_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(sro_rise),
		.pulse(sro_tick)
	);
	rtt_div #(
		.DIV(SYS_DIV)
	) u_int_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(1'b1),
		.pulse(int_tick)
	);

	// ************************************************************
	// timing channels
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			assign ch_win[g] = rtt_ch_win(st_ff.phase, g);
			rtt_chan u_chan (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.comp(comp[g]),
				.fine(fine[g]),
				.win(ch_win[g]),
				.earth(st_ff.phase == PH_EARTH),
				.coarse(st_ff.maj_cnt),
				.origin(st_ff.origin),
				.noise_lim(noise_lim),
				.stamp(stamp[g]),
				.stamp_vld(stamp_vld[g]),
				.evt_cnt(evt_cnt[g]),
				.noise_cnt(noise_cnt[g]),
				.noisy(ch_noisy[g])
			);
		end
	endgenerate

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		sro_rise = sro_clk & ~st_ff.sro_q;
		pps_rise = pps & ~st_ff.pps_q;
		tick = st_ff.ref_ok ? sro_tick : int_tick;
		major = st_ff.origin && (st_ff.minor == '0);
		dly = (surf_dly > DLY_W'(SURF_MAX_TICKS)) ? DLY_W'(SURF_MAX_TICKS) : surf_dly;
		end_cnt = TICK_W'(MINOR_TICKS - 1);
		if (st_ff.minor == MINOR_W'(MINORS - 1) && st_ff.pps_lock) begin
			end_cnt = TICK_W'(MINOR_TICKS - 1 + PPS_SLACK);
		end
		nxt_st.sro_q = sro_clk;
		nxt_st.pps_q = pps;
		nxt_st.origin = 1'b0;
		nxt_st.fire = 1'b0;
		// reference presence
		if (sro_rise) begin
			nxt_st.loss = '0;
		end else if (st_ff.loss != LOSS_W'(REF_LOSS_CYC)) begin
			nxt_st.loss = st_ff.loss + 1'b1;
		end
		nxt_st.ref_ok = (st_ff.loss != LOSS_W'(REF_LOSS_CYC));
		// frame sequencing
		if (pps_rise) begin
			nxt_st.pps_lock = 1'b1;
			nxt_st.tick_cnt = '0;
			nxt_st.maj_cnt = '0;
			nxt_st.minor = '0;
			nxt_st.origin = 1'b1;
			nxt_st.phase = PH_EARTH;
		end else if (tick) begin
			nxt_st.maj_cnt = st_ff.maj_cnt + 1'b1;
			if (st_ff.tick_cnt == end_cnt) begin
				nxt_st.tick_cnt = '0;
				nxt_st.origin = 1'b1;
				nxt_st.phase = PH_EARTH;
				if (st_ff.minor == MINOR_W'(MINORS - 1)) begin
					nxt_st.minor = '0;
					nxt_st.maj_cnt = '0;
					nxt_st.pps_lock = 1'b0;
				end else begin
					nxt_st.minor = st_ff.minor + 1'b1;
				end
			end else begin
				nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
				case (st_ff.phase)
					PH_EARTH: begin
						if (st_ff.tick_cnt == TICK_W'(EARTH_TICKS - 1)) begin
							nxt_st.phase = PH_AIM;
						end
					end
					PH_AIM: begin
						if (st_ff.tick_cnt == TICK_W'(FIRE_TICKS - 1)) begin
							nxt_st.fire = 1'b1;
							nxt_st.dly_cnt = '0;
							nxt_st.phase = PH_DELAY;
						end
					end
					PH_DELAY: begin
						if (st_ff.dly_cnt >= dly) begin
							nxt_st.phase = PH_SURF;
						end else begin
							nxt_st.dly_cnt = st_ff.dly_cnt + 1'b1;
						end
					end
					PH_SURF: begin
						if (st_ff.tick_cnt == TICK_W'(TLM_TICKS - 1)) begin
							nxt_st.phase = PH_TLM;
						end
					end
					PH_TLM: begin
						nxt_st.phase = PH_TLM;
					end
					default: begin
						nxt_st.phase = PH_TLM;
					end
				endcase
			end
		end
		// detector controls
		for (int k = 0; k < NUM_RET; k++) begin
			nxt_st.det[k] = det_cfg[k];
			nxt_st.det[k].en = det_cfg[k].en & ~ch_noisy[k+1];
		end
		nxt_st.latch = adc_done;
		// fine timer calibration
		for (int k = 0; k < NUM_TDC; k++) begin
			if (major) begin
				nxt_st.cal_held[k] = st_ff.cal_run[k];
				nxt_st.cal_run[k] = tdc_slip[k] ? CNT_W'(1) : '0;
			end else if (tdc_slip[k]) begin
				nxt_st.cal_run[k] = rtt_sat_inc(st_ff.cal_run[k]);
			end
		end
		// own oscillator against reference
		if (!st_ff.ref_ok) begin
			nxt_st.gate_cnt = '0;
			nxt_st.osc_run = '0;
		end else begin
			nxt_st.osc_run = st_ff.osc_run + 1'b1;
			if (sro_tick) begin
				if (st_ff.gate_cnt == GATE_W'(GATE_TICKS - 1)) begin
					nxt_st.gate_cnt = '0;
					nxt_st.osc_held = st_ff.osc_run + 1'b1;
					nxt_st.osc_run = '0;
				end else begin
					nxt_st.gate_cnt = st_ff.gate_cnt + 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.phase <= PH_TLM;
			st_ff.loss <= LOSS_W'(REF_LOSS_CYC);
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign ref_ok = st_ff.ref_ok;
	assign frame_origin = st_ff.origin;
	assign minor_idx = st_ff.minor;
	assign earth_win = st_ff.phase[0];
	assign surf_win = st_ff.phase[3];
	assign tlm_slot = st_ff.phase[4];
	assign fire_cmd = st_ff.fire;
	assign det_ctl = st_ff.det;
	assign latch_rst = st_ff.latch;
	assign cal_cnt = st_ff.cal_held;
	assign osc_cnt = st_ff.osc_held;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	always_comb begin
		for (int k = 0; k < NUM_RET; k++) begin
			ctl_en[k] = st_ff.det[k].en;
		end
	end
	pps_align_a: assert property (pps_rise
		|=> st_ff.origin && st_ff.minor == '0 && st_ff.phase == PH_EARTH)
		else $error("second pulse did not restart frame");
	minor_len_a: assert property (tick && !pps_rise && st_ff.tick_cnt == end_cnt
		|=> frame_origin && st_ff.tick_cnt == '0)
		else $error("minor frame did not end on count");
	earth_close_a: assert property (tick && !pps_rise && earth_win
		&& st_ff.tick_cnt == TICK_W'(EARTH_TICKS - 1) |=> !earth_win)
		else $error("earth window length wrong");
	fire_time_a: assert property (fire_cmd
		|-> $past(st_ff.tick_cnt) == TICK_W'(FIRE_TICKS - 1))
		else $error("fire not at fire offset");
	surf_open_a: assert property (fire_cmd && surf_dly == '0 && !pps
		|-> ##[1:12] (surf_win || frame_origin))
		else $error("surface window late after fire");
	sro_div_a: assert property (sro_tick |=> !sro_tick [*3])
		else $error("reference tick too frequent");
	int_div_a: assert property (int_tick |=> !int_tick [*4] ##1 int_tick)
		else $error("own tick period wrong");
	latch_rst_a: assert property (adc_done != '0 |=> latch_rst == $past(adc_done))
		else $error("latch reset not issued");
	silence_a: assert property (ch_noisy[NUM_CH-1:1] != '0
		|=> (ctl_en & $past(ch_noisy[NUM_CH-1:1])) == '0)
		else $error("noisy channel left enabled");
	osc_take_a: assert property (st_ff.ref_ok && sro_tick
		&& st_ff.gate_cnt == GATE_W'(GATE_TICKS - 1)
		|=> osc_cnt == OSC_W'($past(st_ff.osc_run) + 1'b1))
		else $error("oscillator count not taken");
	fire_c: cover property (fire_cmd ##[1:300] stamp_vld[CH_FIRE]);
	earth_stamp_c: cover property (stamp_vld[CH_SHARED] && stamp[CH_SHARED].earth);
	ref_loss_c: cover property (ref_ok ##1 !ref_ok);
	silence_c: cover property (ch_noisy[1] ##1 !det_ctl[0].en);
endmodule : rtt_top

// file: verification/rtt_det_model.sv
`timescale 1ns/1ps
// ************************************************************
// detector boards and spacecraft timing
// ************************************************************
module rtt_det_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// bench requests
	input wire logic sro_on,
	input wire logic pps_req,
	input wire logic [5:0] hit,
	// device side
	input wire logic [4:0] latch_rst,
	output logic sro_clk,
	output logic pps,
	output logic [5:0] comp,
	output logic [5:0][15:0] fine,
	output logic [4:0] adc_done,
	output logic [4:0] held
);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sro_clk <= 1'b0;
			pps <= 1'b0;
			comp <= '0;
			fine <= '0;
			adc_done <= '0;
			held <= '0;
		end else begin
			// reference stands still when switched off
			sro_clk <= sro_on & ~sro_clk;
			pps <= pps_req;
			comp <= hit;
			// fine value only meaningful at an edge, scrambled otherwise
			for (int k = 0; k < 6; k++) begin
				fine[k] <= (hit[k] != comp[k]) ? 16'h0a50 + 16'(k) : ~fine[k];
			end
			// peak held from pulse end until the device resets the latch
			for (int k = 0; k < 5; k++) begin
				adc_done[k] <= comp[k+1] & ~hit[k+1];
				if (comp[k+1] & ~hit[k+1]) begin
					held[k] <= 1'b1;
				end else if (latch_rst[k]) begin
					held[k] <= 1'b0;
				end
			end
		end
	end
endmodule : rtt_det_model

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rtt_pkg::*;
	localparam int MT = 100;
	localparam int ET = 10;
	localparam int FT = 20;
	localparam int TT = 60;
	localparam int GT = 50;
	localparam int SD = 4;
	logic sys_clk, rst_n, sro_clk, pps, sro_on, pps_req, ref_ok, frame_origin;
	logic earth_win, surf_win, fire_cmd, tlm_slot;
	logic [4:0] minor_idx, latch_rst, adc_done, held;
	logic [NUM_CH-1:0] hit, comp, stamp_vld;
	logic [NUM_CH-1:0][FINE_W-1:0] fine;
	logic [DLY_W-1:0] surf_dly;
	logic [CNT_W-1:0] noise_lim;
	logic [NUM_TDC-1:0] tdc_slip;
	rtt_det_cfg_t [NUM_RET-1:0] det_cfg, det_ctl;
	rtt_stamp_t [NUM_CH-1:0] stamp;
	logic [NUM_CH-1:0][CNT_W-1:0] evt_cnt, noise_cnt;
	logic [NUM_TDC-1:0][CNT_W-1:0] cal_cnt;
	logic [OSC_W-1:0] osc_cnt;
	int failures = 0;
	int comparisons = 0;
	int cyc = 0;
	int lrst = 0;
	int vlds = 0;
	rtt_top #(.MINOR_TICKS(MT), .EARTH_TICKS(ET), .FIRE_TICKS(FT), .SURF_MAX_TICKS(30),
		.TLM_TICKS(TT), .GATE_TICKS(GT)) rtt_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.sro_clk(sro_clk), .pps(pps), .surf_dly(surf_dly), .det_cfg(det_cfg),
		.noise_lim(noise_lim), .comp(comp), .fine(fine), .adc_done(adc_done),
		.tdc_slip(tdc_slip), .ref_ok(ref_ok), .frame_origin(frame_origin),
		.minor_idx(minor_idx), .earth_win(earth_win), .surf_win(surf_win),
		.fire_cmd(fire_cmd), .tlm_slot(tlm_slot), .det_ctl(det_ctl), .latch_rst(latch_rst),
		.stamp(stamp), .stamp_vld(stamp_vld), .evt_cnt(evt_cnt), .noise_cnt(noise_cnt),
		.cal_cnt(cal_cnt), .osc_cnt(osc_cnt));
	rtt_det_model rtt_det_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .sro_on(sro_on),
		.pps_req(pps_req), .hit(hit), .latch_rst(latch_rst), .sro_clk(sro_clk), .pps(pps),
		.comp(comp), .fine(fine), .adc_done(adc_done), .held(held));
	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		lrst <= lrst + $countones(latch_rst);
		vlds <= vlds + $countones(stamp_vld);
	end
	task automatic stop_test();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	function automatic logic near(input int a, input int b, input int t);
		return (a >= b - t) && (a <= b + t);
	endfunction : near
	function automatic logic sig(input int w);
		case (w)
			0: return frame_origin;
			1: return surf_win;
			2: return ~earth_win;
			3: return frame_origin & (minor_idx == 5'h00);
			4: return ref_ok;
			5: return |osc_cnt;
			default: return ~ref_ok;
		endcase
	endfunction : sig
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask : step
	task automatic wait_sig(input int w, input int lim);
		int n;
		n = 0;
		while (sig(w) !== 1'b1) begin
			step();
			n++;
			if (n > lim) begin
				failures++;
				$display("mismatch timeout on wait %0d", w);
				stop_test();
			end
		end
	endtask : wait_sig
	task automatic pulse(input int k);
		@(posedge sys_clk);
		hit[k] <= 1'b1;
		@(posedge sys_clk);
		hit[k] <= 1'b0;
	endtask : pulse
	task automatic get_stamp(input int k, input logic fl, input logic ea);
		int n;
		n = 0;
		do begin
			step();
			n++;
		end while (stamp_vld[k] !== 1'b1 && n < 4);
		check("stamp_vld", stamp_vld[k], 1);
		check("stamp_fall", stamp[k].fall, fl);
		check("stamp_earth", stamp[k].earth, ea);
		check("stamp_fine", stamp[k].fine, 16'h0a50 + 16'(k));
	endtask : get_stamp
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic sc_frame(input int cpt);
		int n, t_e, t_f, t_s;
		@(posedge sys_clk);
		pps_req <= 1'b1;
		@(posedge sys_clk);
		pps_req <= 1'b0;
		wait_sig(0, 6);
		check("minor_idx", minor_idx, 0);
		check("earth_win", earth_win, 1);
		n = 0;
		t_e = 0;
		t_f = 0;
		t_s = 0;
		while (tlm_slot !== 1'b1 && n < 200 * cpt) begin
			step();
			n++;
			if (t_e == 0 && earth_win !== 1'b1) t_e = n;
			if (fire_cmd === 1'b1) t_f = n;
			if (t_s == 0 && surf_win === 1'b1) t_s = n;
		end
		check("earth_len", near(t_e, ET * cpt, cpt), 1);
		check("fire_time", near(t_f, (FT - 1) * cpt, cpt), 1);
		check("surf_start", near(t_s - t_f, (int'(surf_dly) + 1) * cpt, 1), 1);
		check("tlm_time", near(n - t_f, (TT - FT) * cpt, 1), 1);
	endtask : sc_frame
	task automatic sc_chan();
		logic [CNT_W-1:0] ev [NUM_CH];
		int c0, t0, v0, l0;
		wait_sig(0, MT * 7);
		ev = '{evt_cnt[0], evt_cnt[1], evt_cnt[2], evt_cnt[3], evt_cnt[4], evt_cnt[5]};
		l0 = lrst;
		pulse(1);
		get_stamp(1, 1'b0, 1'b1);
		c0 = int'(stamp[1].coarse);
		t0 = cyc;
		get_stamp(1, 1'b1, 1'b1);
		wait_sig(2, MT * 7);
		v0 = vlds;
		pulse(2);
		pulse(2);
		repeat (4) step();
		check("outside_vld", vlds, v0);
		check("outside_evt", evt_cnt[2], ev[2]);
		wait_sig(1, MT * 7);
		for (int k = 0; k < NUM_CH; k++) begin
			pulse(k);
			get_stamp(k, 1'b0, 1'b0);
			if (k == 0) begin
				check("coarse", near(int'(stamp[0].coarse) - c0, (cyc - t0) / 5, 1), 1);
			end
			get_stamp(k, 1'b1, 1'b0);
			check("evt_cnt", evt_cnt[k], ev[k] + ((k == 1) ? 4 : 2));
		end
		repeat (3) step();
		check("latch_held", held, 0);
		check("latch_rst", lrst - l0, 8);
	endtask : sc_chan
	task automatic sc_noise();
		wait_sig(0, MT * 7);
		step();
		check("noise_ch2", noise_cnt[2], 3);
		check("noise_ch1", noise_cnt[1], 2);
		step();
		check("en_noisy", det_ctl[1].en, 0);
		check("en_quiet", det_ctl[0].en, 1);
		check("gain", det_ctl[0].gain, 12'h100);
		check("thr", det_ctl[3].thr, 12'h203);
		step();
		wait_sig(0, MT * 7);
		repeat (2) step();
		check("en_back", det_ctl[1].en, 1);
	endtask : sc_noise
	task automatic sc_major();
		int n;
		logic [4:0] last;
		wait_sig(3, MINORS * MT * 7);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			tdc_slip <= '1;
			@(posedge sys_clk);
			tdc_slip <= '0;
		end
		n = 0;
		do begin
			last = minor_idx;
			step();
			wait_sig(0, MT * 7);
			n++;
		end while (minor_idx !== 5'h00 && n < 40);
		check("minor_count", n, MINORS);
		check("minor_last", last, MINORS - 1);
		step();
		for (int j = 0; j < NUM_TDC; j++) check("cal_cnt", cal_cnt[j], 3);
	endtask : sc_major
	task automatic sc_ref();
		int t;
		@(posedge sys_clk);
		sro_on <= 1'b1;
		wait_sig(4, 10);
		wait_sig(5, GT * 8 * 3);
		check("osc_cnt", near(int'(osc_cnt), GT * 8, 2), 1);
		@(posedge sys_clk);
		surf_dly <= '0;
		sc_frame(8);
		@(posedge sys_clk);
		sro_on <= 1'b0;
		surf_dly <= 15'(SD);
		wait_sig(6, 16);
		step();
		wait_sig(0, MT * 7);
		t = cyc;
		step();
		wait_sig(0, MT * 7);
		check("free_run", near(cyc - t, MT * 5, 1), 1);
	endtask : sc_ref
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst_n = 1'b0;
		sro_on = 1'b0;
		pps_req = 1'b0;
		hit = '0;
		surf_dly = 15'(SD);
		noise_lim = 16'h0002;
		tdc_slip = '0;
		for (int k = 0; k < NUM_RET; k++) det_cfg[k] = {12'h100 + 12'(k), 12'h200 + 12'(k), 1'b1};
		repeat (20) @(posedge sys_clk);
		#1;
		check("rst_tlm", tlm_slot, 1);
		check("rst_ref", ref_ok, 0);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		sc_frame(5);
		sc_chan();
		sc_noise();
		sc_major();
		sc_ref();
		stop_test();
	end
endmodule : testbench
